// >>> rtl/dfg_consts.vh
// diag frame generator: register indices, field positions and reset values
// assumes the includer uses 32-bit ahb data, one register per aligned word
`ifndef DFG_CONSTS_VH
`define DFG_CONSTS_VH

// register indices; byte address is four times the index
`define DFG_IDX_ENABLE 16'h8020
`define DFG_IDX_CONTROL 16'h8021
`define DFG_IDX_CONT 16'h8022
`define DFG_IDX_IRQ_EN 16'h8023
`define DFG_IDX_LENGTH 16'h8025
`define DFG_IDX_GAP 16'h8026
`define DFG_IDX_CNT_HI 16'h8027
`define DFG_IDX_CNT_LO 16'h8028
`define DFG_IDX_DONE 16'h8029
`define DFG_IDX_DIAG_CLK 16'h8030
`define DFG_IDX_IRQ_STAT 16'h8031

// field positions
`define DFG_RESTART_BIT 3
`define DFG_PAT_MSB 2

// reset values
`define DFG_RST_PATTERN 3'h1
`define DFG_RST_LENGTH 16'h006b
`define DFG_RST_GAP 16'h000c
`define DFG_RST_CNT_HI 16'h0000
`define DFG_RST_CNT_LO 16'h0100

// pattern select codes
`define DFG_PAT_STOP 3'h0
`define DFG_PAT_RANDOM 3'h1
`define DFG_PAT_ZERO 3'h2
`define DFG_PAT_ONES 3'h3
`define DFG_PAT_ALT 3'h4
`define DFG_PAT_DOWN 3'h5

// frame overhead bytes: two addresses, length field, check sequence
`define DFG_ADDR_BYTES 17'h0_0006
`define DFG_HDR_BYTES 17'h0_000e
`define DFG_FCS_BYTES 17'h0_0004

// timing: 10 Mb/s line gives 800 ns per byte, clock period 4 ns
`define DFG_BYTE_TIME_NS 800
`define DFG_CLK_PERIOD_NS 4
`define DFG_BYTE_CYCLES (`DFG_BYTE_TIME_NS / `DFG_CLK_PERIOD_NS)

`define DFG_CRC_POLY 32'hedb8_8320
`define DFG_LFSR_SEED 32'h1234_5678

`endif

// >>> rtl/dfg_frame_gen.v
// diag frame generator: ahb-lite register slave plus byte-wide test frame source
// assumes one clock hclk, the phy transmit path takes one byte per phy_tx_strobe,
// and the mac transmit inputs are synchronous to hclk.
// the subsystem interrupt mask and status registers live outside and take the exported flag.
//
// Functional notes
// - writing one to control bit 3 restarts generation; the bit clears itself
// - pattern 000 finishes the current frame, then sends no more frames
// - pattern 001, the reset value, fills payloads with random data
// - pattern 010 gives all-zero payloads
// - pattern 011 gives all-one payloads
// - pattern 100 gives payload bytes of 0x55
// - pattern 101 gives payload bytes counting down from 255, wrapping back to 255 after 0
// - continuous mode set keeps sending frames until disabled or reconfigured
// - continuous mode clear sends one burst of the programmed frame count
// - frame count is 32 bits: upper half and lower half in two registers
// - frame counter reloads whenever generation is enabled or restarted
// - completion raises an interrupt only while the interrupt enable is set
// - completion interrupt status shows in the subsystem latched status bit
// - length is payload only; add 6+6 address, 2 length, 4 check bytes
// - idle gap of the programmed byte count between consecutive frames; a zero count gives one byte
// - while enabled, phy data comes from generator; runs only with diag clock on
// - done flag sets on completion and clears when software reads it
`timescale 1ns/10ps
`include "dfg_consts.vh"

module dfg_frame_gen #(
    parameter BYTE_DIV = `DFG_BYTE_CYCLES,
    parameter [47:0] DEST_ADDR = 48'hffff_ffff_ffff,
    parameter [47:0] SRC_ADDR = 48'h0200_0000_0001
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // mac transmit side
    input wire [7:0] mac_tx_data,
    input wire mac_tx_en,
    // phy transmit side
    output reg [7:0] phy_tx_data,
    output reg phy_tx_en,
    output reg phy_tx_strobe,
    // latched completion flag toward the subsystem status register
    output wire checker_generator_irq_flag
);

    // sequencer states; the idle state also sends the byte in which the next frame is decided
    localparam ST_IDLE = 2'd0;
    localparam ST_SEND = 2'd1;
    localparam ST_GAP = 2'd2;

    // one byte step of the reflected crc-32
    // least significant bit first, the order in which bits leave on the line
    function [31:0] crc_byte;
        input [31:0] crc;
        input [7:0] data;
        integer i;
        reg [31:0] c;
        begin
            c = crc ^ {24'h00_0000, data};
            for (i = 0; i < 8; i = i + 1) begin
                c = c[0] ? ((c >> 1) ^ `DFG_CRC_POLY) : (c >> 1);
            end
            crc_byte = c;
        end
    endfunction

    // register state
    reg generator_on_q;
    reg diagnostic_clock_on_q;
    reg [2:0] payload_pattern_select_q;
    reg generator_restart_bit_q;
    reg continuous_mode_select_q;
    reg completion_irq_enable_q;
    reg [15:0] payload_length_bytes_q;
    reg [15:0] gap_length_bytes_q;
    reg [15:0] frame_count_upper_q;
    reg [15:0] frame_count_lower_q;

    // read-to-clear status flags
    reg generation_complete_flag_q;
    reg irq_flag_q;

    // bus pipeline
    reg wr_pend_q;
    reg [15:0] wr_idx_q;
    // hsize is ignored: every register is one aligned word
    wire addr_phase = hsel & htrans[1] & hready;
    wire [15:0] a_idx = haddr[17:2];
    wire rd_now = addr_phase & ~hwrite;
    wire wr_now = wr_pend_q;
    // reading the done or latched status register clears it in the address phase
    wire rd_done = rd_now & (a_idx == `DFG_IDX_DONE);
    wire rd_irq = rd_now & (a_idx == `DFG_IDX_IRQ_STAT);

    // generator state
    reg [1:0] state_q;
    // frame position, gap and remaining-frame counters
    reg [16:0] pos_q;
    reg [15:0] gap_q;
    reg [31:0] remain_q;

    // check sequence and payload pattern state
    reg [31:0] crc_q;
    reg [31:0] lfsr_q;
    reg [7:0] down_q;

    // settings latched at frame start
    reg [2:0] pat_q;
    reg [15:0] len_q;

    // enable edge detect, byte divider and completion pulse
    reg on_prev_q;
    reg [15:0] div_q;
    reg done_evt;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign checker_generator_irq_flag = irq_flag_q;

    // write data arrives one cycle after its address phase
    // the write lands at the end of its data phase; a read right behind it sees the old value
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 16'h0000;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            wr_idx_q <= a_idx;
        end
    end

    // read data is registered at the address phase so it stands in the data phase
    // unmapped indices and reserved bits read as zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_now) begin
            case (a_idx)
                `DFG_IDX_ENABLE: hrdata <= {31'h0000_0000, generator_on_q};
                `DFG_IDX_CONTROL: hrdata <= {28'h000_0000, generator_restart_bit_q, payload_pattern_select_q};
                `DFG_IDX_CONT: hrdata <= {31'h0000_0000, continuous_mode_select_q};
                `DFG_IDX_IRQ_EN: hrdata <= {31'h0000_0000, completion_irq_enable_q};
                `DFG_IDX_LENGTH: hrdata <= {16'h0000, payload_length_bytes_q};
                `DFG_IDX_GAP: hrdata <= {16'h0000, gap_length_bytes_q};
                `DFG_IDX_CNT_HI: hrdata <= {16'h0000, frame_count_upper_q};
                `DFG_IDX_CNT_LO: hrdata <= {16'h0000, frame_count_lower_q};
                `DFG_IDX_DONE: hrdata <= {31'h0000_0000, generation_complete_flag_q};
                `DFG_IDX_DIAG_CLK: hrdata <= {31'h0000_0000, diagnostic_clock_on_q};
                `DFG_IDX_IRQ_STAT: hrdata <= {31'h0000_0000, irq_flag_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // software-written control registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            generator_on_q <= 1'b0;
            diagnostic_clock_on_q <= 1'b0;
            payload_pattern_select_q <= `DFG_RST_PATTERN;
            generator_restart_bit_q <= 1'b0;
            continuous_mode_select_q <= 1'b0;
            completion_irq_enable_q <= 1'b0;
            payload_length_bytes_q <= `DFG_RST_LENGTH;
            gap_length_bytes_q <= `DFG_RST_GAP;
            frame_count_upper_q <= `DFG_RST_CNT_HI;
            frame_count_lower_q <= `DFG_RST_CNT_LO;
        end else begin
            // the restart bit stands for one cycle after its write, then clears
            generator_restart_bit_q <= 1'b0;
            if (wr_now) begin
                case (wr_idx_q)
                    `DFG_IDX_ENABLE: generator_on_q <= hwdata[0];
                    `DFG_IDX_CONTROL: begin
                        payload_pattern_select_q <= hwdata[`DFG_PAT_MSB:0];
                        generator_restart_bit_q <= hwdata[`DFG_RESTART_BIT];
                    end
                    `DFG_IDX_CONT: continuous_mode_select_q <= hwdata[0];
                    `DFG_IDX_IRQ_EN: completion_irq_enable_q <= hwdata[0];
                    `DFG_IDX_LENGTH: payload_length_bytes_q <= hwdata[15:0];
                    `DFG_IDX_GAP: gap_length_bytes_q <= hwdata[15:0];
                    `DFG_IDX_CNT_HI: frame_count_upper_q <= hwdata[15:0];
                    `DFG_IDX_CNT_LO: frame_count_lower_q <= hwdata[15:0];
                    `DFG_IDX_DIAG_CLK: diagnostic_clock_on_q <= hwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // sticky flags: a completion in the read cycle wins over the clear
    // the interrupt flag is gated by the interrupt enable; the subsystem mask is applied outside this block
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            generation_complete_flag_q <= 1'b0;
            irq_flag_q <= 1'b0;
        end else begin
            if (done_evt) begin
                generation_complete_flag_q <= 1'b1;
            end else if (rd_done) begin
                generation_complete_flag_q <= 1'b0;
            end
            if (done_evt && completion_irq_enable_q) begin
                irq_flag_q <= 1'b1;
            end else if (rd_irq) begin
                irq_flag_q <= 1'b0;
            end
        end
    end

    // byte-rate enable; it stops while the diagnostic clock is off, which pauses the frame
    // BYTE_DIV cycles per byte models the 10 Mb/s line rate on the fast bus clock
    wire run = generator_on_q & diagnostic_clock_on_q;
    wire tick = run && (div_q == BYTE_DIV - 1);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 16'h0000;
        end else if (!run || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // reload on the rising edge of enable or on a restart write
    // a restart also aborts a frame in flight; the done flag keeps its value
    wire reload = (generator_on_q & ~on_prev_q) | generator_restart_bit_q;
    wire pat_ok = (payload_pattern_select_q != `DFG_PAT_STOP) &&
        (payload_pattern_select_q <= `DFG_PAT_DOWN);
    wire more = continuous_mode_select_q || (remain_q != 32'h0000_0000);
    wire [16:0] pay_end = `DFG_HDR_BYTES + {1'b0, len_q};
    wire [16:0] last_pos = pay_end + `DFG_FCS_BYTES - 17'h0_0001;

    // payload byte from the pattern latched at frame start
    reg [7:0] pay_byte;
    always @* begin
        case (pat_q)
            `DFG_PAT_RANDOM: pay_byte = lfsr_q[7:0];
            `DFG_PAT_ZERO: pay_byte = 8'h00;
            `DFG_PAT_ONES: pay_byte = 8'hff;
            `DFG_PAT_ALT: pay_byte = 8'h55;
            `DFG_PAT_DOWN: pay_byte = down_q;
            default: pay_byte = 8'h00;
        endcase
    end

    // byte at the current frame position: addresses, length, payload, check sequence
    reg [7:0] cur_byte;
    reg [5:0] sh;
    always @* begin
        sh = 6'd0;
        if (pos_q < `DFG_ADDR_BYTES) begin
            sh = 6'd40 - {pos_q[2:0], 3'b000};
            cur_byte = DEST_ADDR[sh +: 8];
        end else if (pos_q < `DFG_HDR_BYTES - 17'h0_0002) begin
            sh = 6'd40 - {pos_q[2:0] - 3'd6, 3'b000};
            cur_byte = SRC_ADDR[sh +: 8];
        end else if (pos_q == `DFG_HDR_BYTES - 17'h0_0002) begin
            // length field, most significant byte first
            cur_byte = len_q[15:8];
        end else if (pos_q == `DFG_HDR_BYTES - 17'h0_0001) begin
            cur_byte = len_q[7:0];
        end else if (pos_q < pay_end) begin
            cur_byte = pay_byte;
        end else begin
            // inverted remainder, least significant byte first
            cur_byte = ~crc_q[7:0];
        end
    end

    // frame sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            pos_q <= 17'h0_0000;
            gap_q <= 16'h0000;
            remain_q <= 32'h0000_0000;
            crc_q <= 32'hffff_ffff;
            lfsr_q <= `DFG_LFSR_SEED;
            down_q <= 8'hff;
            pat_q <= `DFG_RST_PATTERN;
            len_q <= `DFG_RST_LENGTH;
            on_prev_q <= 1'b0;
            done_evt <= 1'b0;
            phy_tx_strobe <= 1'b0;
            phy_tx_data <= 8'h00;
            phy_tx_en <= 1'b0;
        end else begin
            on_prev_q <= generator_on_q;
            done_evt <= 1'b0;
            phy_tx_strobe <= tick;
            if (!generator_on_q) begin
                // disabled: abort any frame, mac data passes through
                state_q <= ST_IDLE;
                phy_tx_data <= mac_tx_data;
                phy_tx_en <= mac_tx_en;
            end else if (reload) begin
                state_q <= ST_IDLE;
                remain_q <= {frame_count_upper_q, frame_count_lower_q};
                phy_tx_data <= 8'h00;
                phy_tx_en <= 1'b0;
            end else if (tick) begin
                case (state_q)
                    ST_IDLE: begin
                        phy_tx_data <= 8'h00;
                        phy_tx_en <= 1'b0;
                        if (pat_ok && more) begin
                            // settings are latched per frame so a change never tears a frame
                            state_q <= ST_SEND;
                            pos_q <= 17'h0_0000;
                            crc_q <= 32'hffff_ffff;
                            down_q <= 8'hff;
                            pat_q <= payload_pattern_select_q;
                            len_q <= payload_length_bytes_q;
                        end
                    end
                    ST_SEND: begin
                        phy_tx_data <= cur_byte;
                        phy_tx_en <= 1'b1;
                        pos_q <= pos_q + 17'h0_0001;
                        // during the check bytes the remainder shifts out instead of updating
                        if (pos_q < pay_end) begin
                            crc_q <= crc_byte(crc_q, cur_byte);
                        end else begin
                            crc_q <= {8'hff, crc_q[31:8]};
                        end
                        // pattern state advances on payload bytes only
                        if ((pos_q >= `DFG_HDR_BYTES) && (pos_q < pay_end)) begin
                            lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
                            down_q <= down_q - 8'h01;
                        end
                        if (pos_q == last_pos) begin
                            // the idle decision byte closes the gap, so the counter starts one short;
                            // a zero gap still costs that one byte, back-to-back frames are not possible
                            gap_q <= gap_length_bytes_q - 16'h0001;
                            state_q <= (gap_length_bytes_q > 16'h0001) ? ST_GAP : ST_IDLE;
                            // the frame count drops only in burst mode
                            if (!continuous_mode_select_q) begin
                                remain_q <= remain_q - 32'h0000_0001;
                                if (remain_q == 32'h0000_0001) begin
                                    done_evt <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_GAP: begin
                        // gap bytes keep enable low with zero data
                        phy_tx_data <= 8'h00;
                        phy_tx_en <= 1'b0;
                        gap_q <= gap_q - 16'h0001;
                        if (gap_q == 16'h0001) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // dfg_frame_gen

// >>> bench/dfg_checker_properties.sv
// concurrent checks on the frame generator ports
// assumes hready is tied to hreadyout and the bench binds this to the frame generator module
`timescale 1ns/10ps
`include "dfg_consts.vh"
module dfg_checker #(
    parameter BYTE_DIV = 4
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus side
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // mac and phy side
    input wire mac_tx_en,
    input wire [7:0] phy_tx_data,
    input wire phy_tx_en,
    input wire phy_tx_strobe,
    input wire checker_generator_irq_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] since_q;
    logic seen_q;
    logic stat_rd;

    // cycles since the last byte tick, saturating so a long pause cannot wrap
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_q <= 8'h0;
            seen_q <= 1'b0;
        end else begin
            since_q <= phy_tx_strobe ? 8'h0 : (since_q == 8'hff ? since_q : since_q + 8'h1);
            seen_q <= seen_q | phy_tx_strobe;
        end
    end
    // a read address phase of the latched status register clears the flag
    assign stat_rd = hsel && htrans[1] && !hwrite && haddr[17:2] == `DFG_IDX_IRQ_STAT;

    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_reserved_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper read bits set");
    a_tick_spacing: assert property (phy_tx_strobe && seen_q |-> since_q >= BYTE_DIV - 1)
        else $error("byte ticks too close");
    a_hold_data: assert property (phy_tx_strobe ##1 !phy_tx_strobe |-> $stable(phy_tx_data) && $stable(phy_tx_en))
        else $error("byte changed between ticks");
    a_irq_hold: assert property (checker_generator_irq_flag && !stat_rd |=> checker_generator_irq_flag)
        else $error("flag dropped unread");
    a_irq_cause: assert property ($rose(checker_generator_irq_flag) |-> $past(phy_tx_en))
        else $error("flag without a frame end");
    a_en_on_tick: assert property ($rose(phy_tx_en) && !$past(mac_tx_en) |-> phy_tx_strobe)
        else $error("frame start off tick");
endmodule // dfg_checker

// >>> bench/dfg_phy_sink.sv
// passive model of the phy transmit path: records frames byte by byte
// assumes one byte per strobe, data and enable sampled at the strobe edge
`timescale 1ns/10ps
module dfg_phy_sink (
    // clock
    input wire hclk,
    // generated byte stream
    input wire [7:0] phy_tx_data,
    input wire phy_tx_en,
    input wire phy_tx_strobe
);
    logic [7:0] bytes_q [0:63];
    int idx = 0;
    int frames = 0;
    int last_len = 0;
    int idle = 0;
    int last_gap = 0;

    // frame ends at the first idle tick; idle ticks before a frame give the gap
    always @(posedge hclk) begin
        if (phy_tx_strobe && phy_tx_en) begin
            if (idx == 0) last_gap = idle;
            if (idx < 64) bytes_q[idx] = phy_tx_data;
            idx = idx + 1;
            idle = 0;
        end else if (phy_tx_strobe) begin
            if (idx != 0) begin
                frames = frames + 1;
                last_len = idx;
            end
            idx = 0;
            idle = idle + 1;
        end
    end
endmodule // dfg_phy_sink

// >>> bench/tb_top.sv
// self-checking bench for the frame generator over ahb-lite
// assumes BYTE_DIV of 4 so a short frame takes about a hundred cycles
`timescale 1ns/10ps
`include "dfg_consts.vh"
module tb_top;
    logic hclk, hresetn, hsel, hwrite, mac_tx_en;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] mac_tx_data;
    wire hreadyout, hresp, phy_tx_en, phy_tx_strobe, irq;
    wire [31:0] hrdata;
    wire [7:0] phy_tx_data;
    int n_fail = 0;
    int n_tests = 0;

    dfg_frame_gen #(.BYTE_DIV(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mac_tx_data(mac_tx_data),
        .mac_tx_en(mac_tx_en), .phy_tx_data(phy_tx_data), .phy_tx_en(phy_tx_en),
        .phy_tx_strobe(phy_tx_strobe), .checker_generator_irq_flag(irq));
    dfg_phy_sink sink (.hclk(hclk), .phy_tx_data(phy_tx_data), .phy_tx_en(phy_tx_en),
        .phy_tx_strobe(phy_tx_strobe));

    task stop_test;
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask

    // one single transfer; entered right after a rising edge, ends with an idle cycle
    task bus(input logic wr_en, input logic [15:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr_en;
        haddr <= {14'h0, idx, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task rdchk(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp, "register read");
    endtask

    task wait_frames(input int n);
        int k;
        k = 0;
        while (sink.frames < n && k < 5000) begin
            @(posedge hclk);
            k++;
        end
        check(k < 5000, 1, "frame wait");
    endtask

    function automatic logic [7:0] pay(input int p, input int i);
        case (p)
            2: return 8'h0;
            3: return 8'hff;
            4: return 8'h55;
            default: return 8'(255 - i);
        endcase
    endfunction

    // reference crc-32 of the first n received bytes, reflected, sent inverted
    function automatic logic [31:0] fcs_of(input int n);
        logic [31:0] c;
        c = 32'hffff_ffff;
        for (int j = 0; j < n; j++) begin
            c = c ^ {24'h00_0000, sink.bytes_q[j]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
        end
        return ~c;
    endfunction

    task t_reset_vals;
        rdchk(`DFG_IDX_CONTROL, 32'h1);
        rdchk(`DFG_IDX_CONT, 32'h0);
        rdchk(`DFG_IDX_IRQ_EN, 32'h0);
        rdchk(`DFG_IDX_LENGTH, 32'h6b);
        rdchk(`DFG_IDX_GAP, 32'hc);
        rdchk(`DFG_IDX_CNT_HI, 32'h0);
        rdchk(`DFG_IDX_CNT_LO, 32'h100);
        rdchk(16'h8024, 32'h0);
    endtask

    task t_burst;
        wr(`DFG_IDX_LENGTH, 32'h4);
        wr(`DFG_IDX_GAP, 32'h2);
        wr(`DFG_IDX_CNT_LO, 32'h2);
        wr(`DFG_IDX_CONTROL, 32'h2);
        wr(`DFG_IDX_IRQ_EN, 32'h1);
        // enabled with the diagnostic clock off: no frames, and mac data stays blocked
        wr(`DFG_IDX_ENABLE, 32'h1);
        mac_tx_en <= 1'b1;
        repeat (100) @(posedge hclk);
        check(phy_tx_en, 0, "mac blocked");
        check(sink.frames, 0, "diag clock off");
        mac_tx_en <= 1'b0;
        wr(`DFG_IDX_DIAG_CLK, 32'h1);
        wait_frames(2);
        check(sink.last_len, 22, "frame bytes");
        check(sink.last_gap, 2, "gap ticks");
        check({sink.bytes_q[12], sink.bytes_q[13]}, 32'h4, "length field");
        for (int b = 0; b < 4; b++) check(sink.bytes_q[14 + b], 32'h0, "payload");
        check({sink.bytes_q[21], sink.bytes_q[20], sink.bytes_q[19], sink.bytes_q[18]}, fcs_of(18), "fcs");
        repeat (200) @(posedge hclk);
        check(sink.frames, 2, "burst size");
        check(irq, 1, "irq flag");
        rdchk(`DFG_IDX_IRQ_STAT, 32'h1);
        check(irq, 0, "irq flag read");
        rdchk(`DFG_IDX_DONE, 32'h1);
        rdchk(`DFG_IDX_DONE, 32'h0);
    endtask

    // restart with each payload pattern, one frame each, interrupt off
    task t_patterns;
        int f;
        wr(`DFG_IDX_IRQ_EN, 32'h0);
        wr(`DFG_IDX_CNT_LO, 32'h1);
        for (int p = 1; p < 6; p++) begin
            f = sink.frames;
            wr(`DFG_IDX_CONTROL, 32'h8 | p);
            wait_frames(f + 1);
            for (int b = 0; b < 4; b++)
                if (p > 1) check(sink.bytes_q[14 + b], pay(p, b), "payload");
            check({sink.bytes_q[21], sink.bytes_q[20], sink.bytes_q[19], sink.bytes_q[18]}, fcs_of(18), "fcs");
            rdchk(`DFG_IDX_CONTROL, p);
            rdchk(`DFG_IDX_DONE, 32'h1);
        end
        repeat (200) @(posedge hclk);
        check(sink.frames, f + 1, "frames per restart");
        check(irq, 0, "irq disabled");
    endtask

    task t_stop;
        int f;
        int codes[3] = '{0, 6, 7};
        foreach (codes[i]) begin
            f = sink.frames;
            wr(`DFG_IDX_CONTROL, 32'h8 | codes[i]);
            repeat (200) @(posedge hclk);
            check(sink.frames, f, "no new frame");
        end
    endtask

    // continuous run beyond the count, then stop mid-frame with pattern zero
    task t_cont;
        int f;
        f = sink.frames;
        wr(`DFG_IDX_CONT, 32'h1);
        wr(`DFG_IDX_CONTROL, 32'ha);
        wait_frames(f + 3);
        repeat (40) @(posedge hclk);
        wr(`DFG_IDX_CONTROL, 32'h0);
        repeat (200) @(posedge hclk);
        check(sink.frames, f + 4, "frame in flight ends");
        f = sink.frames;
        check(sink.last_len, 22, "last frame whole");
        repeat (200) @(posedge hclk);
        check(sink.frames, f, "stopped");
        wr(`DFG_IDX_CNT_HI, 32'hffff_0001);
        rdchk(`DFG_IDX_CNT_HI, 32'h1);
    endtask

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // watchdog far beyond the few thousand cycles the sequence needs
    initial begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        mac_tx_data = 8'h0;
        mac_tx_en = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        mac_tx_data <= 8'h3c;
        mac_tx_en <= 1'b1;
        repeat (3) @(posedge hclk);
        check({phy_tx_en, phy_tx_data}, 32'h13c, "mac pass");
        mac_tx_en <= 1'b0;
        mac_tx_data <= 8'h0;
        @(posedge hclk);
        t_reset_vals;
        t_burst;
        t_patterns;
        t_stop;
        t_cont;
        stop_test;
    end
endmodule // tb_top

bind dfg_frame_gen dfg_checker #(.BYTE_DIV(BYTE_DIV)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mac_tx_en(mac_tx_en), .phy_tx_data(phy_tx_data), .phy_tx_en(phy_tx_en),
    .phy_tx_strobe(phy_tx_strobe), .checker_generator_irq_flag(checker_generator_irq_flag));
